// File: design/qdbr_pkg.sv
// Constants shared by the queued deadline and buffer read command block.
package qdbr_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] QDBR_CMD_OFS = 8'h00;
    localparam logic [7:0] QDBR_STAT_OFS = 8'h04;
    localparam logic [7:0] QDBR_CTRL_OFS = 8'h08;
    localparam logic [7:0] QDBR_FILL_OFS = 8'h0c;
    localparam logic [7:0] QDBR_DATA_OFS = 8'h10;
    localparam logic [7:0] QDBR_LIMIT_OFS = 8'h14;

    // Command opcodes.
    localparam logic [7:0] QDBR_OP_QMGMT = 8'h63;
    localparam logic [7:0] QDBR_OP_RDBUF = 8'he4;
    localparam logic [7:0] QDBR_OP_RDBUF_DMA = 8'he9;

    // Field positions inside the command register.
    localparam int QDBR_OPC_LSB = 0;
    localparam int QDBR_FEAT_LSB = 8;
    localparam int QDBR_CNT_LSB = 16;
    localparam int QDBR_SNUM_LSB = 24;

    // Feature byte layout of the queued management command, and slot position in its count and sector number bytes.
    localparam int QDBR_SUB_LSB = 0;
    localparam logic [3:0] QDBR_SUB_DEADLINE = 4'h1;
    localparam int QDBR_WR_ENF_BIT = 4;
    localparam int QDBR_RD_ENF_BIT = 5;
    localparam int QDBR_SLOT_LSB = 3;

    // Control register layout.
    localparam int QDBR_NCQ_EN_BIT = 0;
    localparam int QDBR_ABT_TYPE_LSB = 4;
    localparam logic [3:0] QDBR_ABT_TYPE_MAX = 4'h3;
    localparam logic [31:0] QDBR_CTRL_RST = 32'h0000_0001;

    // Fill register: bit 31 starts a new buffer write, low half is data.
    localparam int QDBR_FILL_START_BIT = 31;

    // Urgency class that is subject to deadline enforcement.
    localparam logic [1:0] QDBR_URG_DEADLINE = 2'h1;

    // Error and status byte bit positions.
    localparam int QDBR_ERR_REFUSED_BIT = 2;
    localparam int QDBR_ST_BUSY_BIT = 7;
    localparam int QDBR_ST_READY_BIT = 6;
    localparam int QDBR_ST_DSC_BIT = 4;
    localparam int QDBR_ST_DRQ_BIT = 3;
    localparam int QDBR_ST_FAULT_BIT = 0;

    localparam logic [31:0] QDBR_LIMIT_RST = 32'h0000_1000;

    typedef enum logic [1:0] {
        QDBR_IDLE,
        QDBR_EXEC,
        QDBR_PIO,
        QDBR_DMA
    } qdbr_state_type;

endpackage : qdbr_pkg

// File: design/qdbr_cmd.sv
// Queued deadline handling and buffer read command interpreter.
`timescale 1ns/1ns
`default_nettype none

module qdbr_cmd
    import qdbr_pkg::*;
#(
    parameter int SECTOR_WORDS = 256,
    parameter int QUEUE_DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic q_issue,
    input wire logic [4:0] q_issue_slot,
    input wire logic q_issue_write,
    input wire logic [1:0] q_issue_urgency_class,
    input wire logic q_done,
    input wire logic [4:0] q_done_slot,
    input wire logic media_wr,
    input wire logic [7:0] media_wr_addr,
    input wire logic [15:0] media_wr_data,
    output logic dma_valid,
    output logic [15:0] dma_data,
    output logic dma_last,
    input wire logic dma_ready,
    output logic sdb_valid,
    output logic [31:0] sdb_done_mask,
    output logic abort_all
);

    localparam int PW = $clog2(SECTOR_WORDS);
    localparam logic [PW-1:0] LAST_WORD = PW'(SECTOR_WORDS - 1);
    localparam logic [4:0] MAX_SLOT = 5'(QUEUE_DEPTH - 1);

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.

    logic wr_en;
    logic rd_en;
    logic mapped;

    assign mapped = (paddr == QDBR_CMD_OFS) || (paddr == QDBR_STAT_OFS) ||
        (paddr == QDBR_CTRL_OFS) || (paddr == QDBR_FILL_OFS) ||
        (paddr == QDBR_DATA_OFS) || (paddr == QDBR_LIMIT_OFS);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // Registers and state.

    qdbr_state_type state_q;
    logic [31:0] cmd_q;
    logic [31:0] ctrl_q;
    logic [31:0] limit_q;
    logic [7:0] error_q;
    logic fault_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW-1:0] fill_ptr_q;
    logic [15:0] buf_mem [SECTOR_WORDS];
    logic [31:0] outstanding_q;
    logic [31:0] is_write_q;
    logic [31:0] urgent_q;
    logic wr_enf_q;
    logic rd_enf_q;
    logic timer_on_q;
    logic [31:0] timer_q;

    logic cmd_wr;
    logic data_rd;
    logic [7:0] opcode;
    logic [7:0] feature;
    logic [4:0] own_slot;
    logic [4:0] target_slot;
    logic [3:0] abort_type;
    logic is_deadline;
    logic refuse;
    logic accept_sub;
    logic pio_end;
    logic dma_end;
    logic expire;
    logic [31:0] enforced;
    logic [31:0] done_bit;

    assign cmd_wr = wr_en && (paddr == QDBR_CMD_OFS) &&
        (state_q == QDBR_IDLE);
    assign data_rd = rd_en && (paddr == QDBR_DATA_OFS) &&
        (state_q == QDBR_PIO);
    assign opcode = cmd_q[QDBR_OPC_LSB +: 8];
    assign feature = cmd_q[QDBR_FEAT_LSB +: 8];
    assign own_slot = cmd_q[QDBR_CNT_LSB + QDBR_SLOT_LSB +: 5];
    assign target_slot = cmd_q[QDBR_SNUM_LSB + QDBR_SLOT_LSB +: 5];
    assign abort_type = ctrl_q[QDBR_ABT_TYPE_LSB +: 4];
    assign is_deadline = (opcode == QDBR_OP_QMGMT) &&
        (feature[QDBR_SUB_LSB +: 4] == QDBR_SUB_DEADLINE);

    // Any failed check, or an opcode this block does not carry, aborts.
    always_comb begin
        refuse = 1'b0;
        if (state_q == QDBR_EXEC) begin
            if (!is_deadline && opcode != QDBR_OP_RDBUF &&
                opcode != QDBR_OP_RDBUF_DMA) begin
                refuse = 1'b1;
            end
            if (is_deadline) begin
                if (!ctrl_q[QDBR_NCQ_EN_BIT]) begin
                    refuse = 1'b1;
                end
                if (target_slot == own_slot) begin
                    refuse = 1'b1;
                end
                if (target_slot > MAX_SLOT) begin
                    refuse = 1'b1;
                end
                if (abort_type > QDBR_ABT_TYPE_MAX) begin
                    refuse = 1'b1;
                end
            end
        end
    end

    assign accept_sub = (state_q == QDBR_EXEC) && is_deadline && !refuse;
    assign pio_end = data_rd && (rd_ptr_q == LAST_WORD);
    assign dma_end = (state_q == QDBR_DMA) && dma_ready &&
        (rd_ptr_q == LAST_WORD);

    ////////////////////////////////////////////////////////////////////////
    // Command sequencing.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= QDBR_IDLE;
        end else begin
            case (state_q)
                QDBR_IDLE: begin
                    if (cmd_wr) begin
                        state_q <= QDBR_EXEC;
                    end
                end
                QDBR_EXEC: begin
                    if (refuse || is_deadline) begin
                        state_q <= QDBR_IDLE;
                    end else if (opcode == QDBR_OP_RDBUF) begin
                        state_q <= QDBR_PIO;
                    end else begin
                        state_q <= QDBR_DMA;
                    end
                end
                QDBR_PIO: begin
                    if (pio_end) begin
                        state_q <= QDBR_IDLE;
                    end
                end
                QDBR_DMA: begin
                    if (dma_end) begin
                        state_q <= QDBR_IDLE;
                    end
                end
                default: begin
                    state_q <= QDBR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= '0;
            ctrl_q <= QDBR_CTRL_RST;
            limit_q <= QDBR_LIMIT_RST;
        end else if (wr_en) begin
            if (cmd_wr) begin
                cmd_q <= merge(cmd_q, pwdata, pstrb);
            end
            if (paddr == QDBR_CTRL_OFS) begin
                ctrl_q <= merge(ctrl_q, pwdata, pstrb);
            end
            if (paddr == QDBR_LIMIT_OFS) begin
                limit_q <= merge(limit_q, pwdata, pstrb);
            end
        end
    end

    // Outcome flags of the last command; a new command clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_q <= '0;
            fault_q <= 1'b0;
        end else if (refuse || expire) begin
            error_q[QDBR_ERR_REFUSED_BIT] <= 1'b1;
            fault_q <= 1'b1;
        end else if (cmd_wr) begin
            error_q <= '0;
            fault_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sector buffer.

    // Buffer fill pointer marks the region of the last buffer write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_ptr_q <= '0;
        end else if (wr_en && paddr == QDBR_FILL_OFS) begin
            if (pwdata[QDBR_FILL_START_BIT]) begin
                fill_ptr_q <= '0;
            end else begin
                fill_ptr_q <= fill_ptr_q + PW'(1);
            end
        end
    end

    // Media traffic may overwrite the stored sector.
    always_ff @(posedge pclk) begin
        if (wr_en && paddr == QDBR_FILL_OFS &&
            !pwdata[QDBR_FILL_START_BIT]) begin
            buf_mem[fill_ptr_q] <= pwdata[15:0];
        end else if (media_wr) begin
            buf_mem[media_wr_addr[PW-1:0]] <= media_wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ptr_q <= '0;
        end else if (state_q == QDBR_EXEC) begin
            rd_ptr_q <= '0;
        end else if (data_rd || (dma_valid && dma_ready)) begin
            rd_ptr_q <= rd_ptr_q + PW'(1);
        end
    end

    assign dma_valid = (state_q == QDBR_DMA);
    assign dma_data = buf_mem[rd_ptr_q];
    assign dma_last = dma_valid && (rd_ptr_q == LAST_WORD);

    ////////////////////////////////////////////////////////////////////////
    // Queued command tracking and deadline enforcement.

    assign done_bit = q_done ? (32'h0000_0001 << q_done_slot) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outstanding_q <= '0;
            is_write_q <= '0;
            urgent_q <= '0;
        end else if (expire) begin
            outstanding_q <= '0;
        end else begin
            outstanding_q <= outstanding_q & ~done_bit;
            if (q_issue) begin
                outstanding_q[q_issue_slot] <= 1'b1;
                is_write_q[q_issue_slot] <= q_issue_write;
                urgent_q[q_issue_slot] <=
                    (q_issue_urgency_class == QDBR_URG_DEADLINE);
            end
        end
    end

    // Only deadline class commands of an enforced direction count.
    assign enforced = outstanding_q & urgent_q &
        ((is_write_q & {32{wr_enf_q}}) |
         (~is_write_q & {32{rd_enf_q}}));

    assign expire = timer_on_q && (timer_q == 32'h0) && (enforced != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_enf_q <= 1'b0;
            rd_enf_q <= 1'b0;
            timer_on_q <= 1'b0;
            timer_q <= '0;
        end else if (accept_sub) begin
            wr_enf_q <= feature[QDBR_WR_ENF_BIT];
            rd_enf_q <= feature[QDBR_RD_ENF_BIT];
            timer_on_q <= feature[QDBR_WR_ENF_BIT] ||
                feature[QDBR_RD_ENF_BIT];
            timer_q <= limit_q;
        end else if (timer_on_q) begin
            if (timer_q == 32'h0 || enforced == '0) begin
                timer_on_q <= 1'b0;
            end else begin
                timer_q <= timer_q - 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion reporting.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdb_valid <= 1'b0;
            sdb_done_mask <= '0;
            abort_all <= 1'b0;
        end else begin
            sdb_valid <= accept_sub;
            sdb_done_mask <= accept_sub ?
                ((32'h0000_0001 << own_slot) | done_bit) : '0;
            abort_all <= expire;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    logic [7:0] status_byte;

    always_comb begin
        status_byte = '0;
        status_byte[QDBR_ST_BUSY_BIT] = (state_q == QDBR_EXEC) ||
            (state_q == QDBR_DMA);
        status_byte[QDBR_ST_READY_BIT] = 1'b1;
        status_byte[QDBR_ST_DSC_BIT] = 1'b1;
        status_byte[QDBR_ST_DRQ_BIT] = (state_q == QDBR_PIO);
        status_byte[QDBR_ST_FAULT_BIT] = fault_q;
    end

    always_comb begin
        prdata = '0;
        if (rd_en) begin
            case (paddr)
                QDBR_CMD_OFS: prdata = cmd_q;
                QDBR_STAT_OFS: prdata = {15'h0, timer_on_q, error_q,
                    status_byte};
                QDBR_CTRL_OFS: prdata = ctrl_q;
                QDBR_FILL_OFS: prdata = {{(32-PW){1'b0}}, fill_ptr_q};
                QDBR_DATA_OFS: prdata = (state_q == QDBR_PIO) ?
                    {16'h0, buf_mem[rd_ptr_q]} : '0;
                QDBR_LIMIT_OFS: prdata = limit_q;
                default: prdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    int pio_words;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pio_words <= 0;
        end else if (state_q == QDBR_EXEC) begin
            pio_words <= 0;
        end else if (data_rd) begin
            pio_words <= pio_words + 1;
        end
    end

    sub_select_a: assert property (
        accept_sub |-> feature[3:0] == 4'h1)
        else $error("deadline accepted with wrong subcommand");
    refuse_flags_a: assert property (
        refuse |=> error_q[2] && status_byte[0] && !status_byte[7])
        else $error("refusal flags or busy wrong");
    ncq_off_a: assert property (
        state_q == QDBR_EXEC && is_deadline && !ctrl_q[0] |-> refuse)
        else $error("deadline accepted with queuing off");
    own_slot_a: assert property (
        accept_sub |-> target_slot != own_slot)
        else $error("target slot equal to own slot accepted");
    bad_slot_a: assert property (
        accept_sub |-> target_slot <= MAX_SLOT)
        else $error("invalid target slot accepted");
    abort_type_a: assert property (
        accept_sub |-> abort_type <= 4'h3)
        else $error("unsupported abort type accepted");
    sdb_send_a: assert property (
        accept_sub |=> sdb_valid && sdb_done_mask[$past(own_slot)]
            && !fault_q)
        else $error("no set device bits after success");
    deadline_a: assert property (
        expire |=> abort_all && outstanding_q == 32'h0)
        else $error("deadline overrun did not abort all");
    pio_len_a: assert property (
        pio_end |-> pio_words == SECTOR_WORDS - 1 ##1 state_q == QDBR_IDLE)
        else $error("buffer read length not one sector");
    dma_last_a: assert property (
        dma_valid && dma_ready && dma_last |=> !dma_valid)
        else $error("dma did not stop after one sector");

    sub_ok_c: cover property (accept_sub ##1 sdb_valid);
    refuse_c: cover property (refuse);
    pio_done_c: cover property (pio_end);
    dma_done_c: cover property (dma_end);

endmodule : qdbr_cmd

`default_nettype wire

// File: sim/qdbr_host_model.sv
// Host side DMA sink that takes buffer words promptly or with stalls.
`timescale 1ns/1ns
`default_nettype none

module qdbr_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic dma_ready
);

    // When slow is set, ready drops at random to stall the sender.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ready <= 1'b0;
        end else begin
            dma_ready <= !slow || ($urandom % 3 == 0);
        end
    end

endmodule : qdbr_host_model

`default_nettype wire

// File: sim/tb_queued_deadline_and_buffer_read_cmds.sv
// Self-checking bench for the queued deadline and buffer read command block.
`timescale 1ns/1ns
`default_nettype none

module tb_queued_deadline_and_buffer_read_cmds import qdbr_pkg::*;;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic q_issue = 1'b0;
    logic q_issue_write = 1'b0;
    logic q_done = 1'b0;
    logic media_wr = 1'b0;
    logic slow = 1'b0;
    logic [4:0] q_issue_slot = 5'h00;
    logic [4:0] q_done_slot = 5'h00;
    logic [1:0] q_issue_urgency_class = 2'h0;
    logic [7:0] media_wr_addr = 8'h00;
    logic [15:0] media_wr_data = 16'h0000;
    logic dma_valid;
    logic dma_last;
    logic dma_ready;
    logic sdb_valid;
    logic abort_all;
    logic [15:0] dma_data;
    logic [31:0] sdb_done_mask;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [32:0] rd_q[$];
    logic [16:0] dma_q[$];
    logic [31:0] evt_q[$];
    logic [31:0] ab_q[$];
    logic [15:0] mem [256];
    logic [31:0] bad_ctrl [6] = '{32'h0, 32'h1, 32'h1, 32'h41, 32'h1, 32'h1};
    logic [7:0] bad_op [6] = '{8'h63, 8'h63, 8'h63, 8'h63, 8'h63, 8'h00};
    logic [7:0] bad_f [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
    logic [4:0] bad_t [6] = '{5'h02, 5'h09, 5'h14, 5'h02, 5'h02, 5'h02};
    logic dl_wr [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic [1:0] dl_cls [4] = '{2'h1, 2'h2, 2'h1, 2'h1};
    logic [7:0] dl_f [4] = '{8'h11, 8'h11, 8'h11, 8'h21};
    logic dl_ab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    always #10 pclk = ~pclk;

    qdbr_cmd #(.SECTOR_WORDS(256), .QUEUE_DEPTH(16)) qdbr_cmd_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .q_issue(q_issue), .q_issue_slot(q_issue_slot),
        .q_issue_write(q_issue_write),
        .q_issue_urgency_class(q_issue_urgency_class),
        .q_done(q_done), .q_done_slot(q_done_slot), .media_wr(media_wr),
        .media_wr_addr(media_wr_addr), .media_wr_data(media_wr_data),
        .dma_valid(dma_valid), .dma_data(dma_data), .dma_last(dma_last),
        .dma_ready(dma_ready), .sdb_valid(sdb_valid),
        .sdb_done_mask(sdb_done_mask), .abort_all(abort_all)
    );

    qdbr_host_model qdbr_host_model_inst (
        .pclk(pclk), .presetn(presetn), .slow(slow), .dma_ready(dma_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic chk_rd(input string n, input logic [32:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_rd

    task automatic chk_dma(input string n, input logic [16:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_dma

    task automatic chk_evt(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk_evt

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // The host places its own and the target slot in bits 7 to 3.
    function automatic logic [31:0] cmd(input logic [7:0] op, f,
            input logic [4:0] own, tgt);
        return {tgt, 3'h0, own, 3'h0, f, op};
    endfunction : cmd

    ////////////////////////////////////////////////////////////////////////
    // Results are taken off the note queues as the outputs show them.
    always @(posedge pclk) begin
        cycles++;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk_rd("apb read", rd_q.size() ? rd_q.pop_front() : 'x,
                {pslverr, prdata});
        end
        if (dma_valid === 1'b1 && dma_ready) begin
            chk_dma("dma word", dma_q.size() ? dma_q.pop_front() : 'x,
                {dma_last, dma_data});
        end
        if (sdb_valid === 1'b1) begin
            chk_evt("set bits mask", evt_q.size() ? evt_q.pop_front() : 'x,
                sdb_done_mask);
        end
        if (abort_all === 1'b1) begin
            chk_evt("abort all", ab_q.size() ? ab_q.pop_front() : 'x,
                {31'h0, abort_all});
        end
        if (cycles == 20000) begin
            fails++;
            $display("unexpected timeout expected 0 seen %0d", cycles);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h1e40524a));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(QDBR_STAT_OFS, 33'h50);
        rd(8'h18, {1'b1, 32'h0});
        apb(1'b1, QDBR_FILL_OFS, 32'h8000_0000);
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'($urandom);
            apb(1'b1, QDBR_FILL_OFS, {16'h0, mem[i]});
        end
        @(posedge pclk);
        media_wr <= 1'b1;
        media_wr_addr <= 8'h05;
        media_wr_data <= ~mem[5];
        @(posedge pclk);
        media_wr <= 1'b0;
        mem[5] = ~mem[5];
        apb(1'b1, QDBR_CMD_OFS,
            cmd(QDBR_OP_RDBUF, 8'h0, 5'h0, 5'h0));
        rd(QDBR_STAT_OFS, 33'h58);
        for (int i = 0; i < 256; i++) begin
            rd(QDBR_DATA_OFS, {17'h0, mem[i]});
        end
        rd(QDBR_DATA_OFS, 33'h0);
        rd(QDBR_STAT_OFS, 33'h50);
        slow <= 1'b1;
        for (int i = 0; i < 256; i++) begin
            dma_q.push_back({i == 255, mem[i]});
        end
        apb(1'b1, QDBR_CMD_OFS, cmd(QDBR_OP_RDBUF_DMA, 8'h0, 5'h0, 5'h0));
        rd(QDBR_STAT_OFS, 33'hd0);
        for (int i = 0; i < 2000 && dma_valid !== 1'b0; i++) @(posedge pclk);
        slow <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, QDBR_CTRL_OFS, bad_ctrl[i]);
            apb(1'b1, QDBR_CMD_OFS, cmd(bad_op[i], bad_f[i], 5'h09,
                bad_t[i]));
            rd(QDBR_STAT_OFS, 33'h451);
        end
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, QDBR_CTRL_OFS, {24'h0, 4'(t), 4'h1});
            evt_q.push_back(t == 3 ? 32'h210 : 32'h200);
            apb(1'b1, QDBR_CMD_OFS, cmd(QDBR_OP_QMGMT, 8'h01, 5'h09, 5'h02));
            // A completion in the acceptance cycle rides in the same mask.
            q_done <= (t == 3);
            q_done_slot <= 5'h04;
            @(posedge pclk);
            q_done <= 1'b0;
            rd(QDBR_STAT_OFS, 33'h50);
        end
        apb(1'b1, QDBR_LIMIT_OFS, 32'h14);
        for (int j = 0; j < 4; j++) begin
            @(posedge pclk);
            q_issue <= 1'b1;
            q_issue_slot <= 5'h03;
            q_issue_write <= dl_wr[j];
            q_issue_urgency_class <= dl_cls[j];
            @(posedge pclk);
            q_issue <= 1'b0;
            evt_q.push_back(32'h200);
            if (dl_ab[j]) ab_q.push_back(32'h1);
            apb(1'b1, QDBR_CMD_OFS, cmd(QDBR_OP_QMGMT, dl_f[j], 5'h09,
                5'h02));
            repeat (40) @(posedge pclk);
            rd(QDBR_STAT_OFS, dl_ab[j] ? 33'h451 : 33'h50);
            q_done <= 1'b1;
            q_done_slot <= 5'h03;
            @(posedge pclk);
            q_done <= 1'b0;
        end
        repeat (5) @(posedge pclk);
        if (rd_q.size() + dma_q.size() + evt_q.size() + ab_q.size() != 0) begin
            fails++;
            $display("unexpected pending notes expected 0 seen %0d",
                rd_q.size() + dma_q.size() + evt_q.size() + ab_q.size());
        end
        stop_test();
    end

endmodule : tb_queued_deadline_and_buffer_read_cmds

`default_nettype wire
